// [rrc_pkg.sv]
// Function
// - Root base bits 63:12 hold page-aligned table.
// - Root base bits from host width upward ignored.
// - Root base reads return last written value.
// - Set-root clears status, sets it when adopted.
// - Upper-byte write with bit 63 starts invalidation.
// - Completion clears invalidate bit, reports actual granularity.
// - Flush write buffers before context invalidation when flag set.
// - Requested granularity: reserved, global, domain, device.
// - Hardware may invalidate coarser than requested.
// - Actual granularity reported in bits 60:59.
// - Device-selective reported only for device requests.
// - Function mask hides high function bits.
// - Function mask and source read undefined.
// - Domain bits beyond supported width ignored.
// - Address and command registers adjacent, 8 apart.
// - Extended capability advertises address register offset.
package rrc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CAP_LO = 12'h008;
  localparam logic [11:0] CAP_HI = 12'h00c;
  localparam logic [11:0] ECAP_LO = 12'h010;
  localparam logic [11:0] ECAP_HI = 12'h014;
  localparam logic [11:0] CTRL = 12'h018;
  localparam logic [11:0] ROOT_LO = 12'h020;
  localparam logic [11:0] ROOT_HI = 12'h024;
  localparam logic [11:0] CCMD_LO = 12'h028;
  localparam logic [11:0] CCMD_HI = 12'h02c;
  localparam logic [11:0] IVA_LO = 12'h100;
  localparam logic [11:0] IVA_HI = 12'h104;
  localparam logic [11:0] TLB_LO = IVA_LO + 12'h008;
  localparam logic [11:0] TLB_HI = IVA_LO + 12'h00c;
  localparam int ADDR_OFS_POS = 8;
  localparam int FLUSH_REQ_POS = 4;
  localparam int SET_ROOT_POS = 0;
  localparam int RPS_POS = 1;
  localparam logic [63:0] ROOT_PAGE_MASK = 64'hffff_ffff_ffff_f000;
  localparam logic [1:0] GRAN_RSVD = 2'h0;
  localparam logic [1:0] GRAN_GLOBAL = 2'h1;
  localparam logic [1:0] GRAN_DOMAIN = 2'h2;
  localparam logic [1:0] GRAN_DEVICE = 2'h3;
  localparam logic [2:0] TLB_GRAN_GLOBAL = 3'h1;
  localparam logic [31:0] TLB_HI_MASK = 32'hf000_ffff;
  localparam logic [63:0] ROOT_RESET = 64'h0;

  typedef enum logic [1:0] {CTX_IDLE, CTX_FLUSH, CTX_INV} rrc_ctx_e;

  typedef struct packed {
    logic [1:0] gran;
    logic [15:0] dom_id;
    logic [15:0] src_id;
    logic [2:0] func_care;
  } rrc_ctx_inv_s;

  function automatic logic [31:0] rrc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : rrc_merge
endpackage : rrc_pkg

// [rrc_remap_ctl.sv]
`timescale 1ns/1ps
module rrc_remap_ctl
  import rrc_pkg::*;
#(
  parameter int HOST_ADDR_W = 39,
  parameter int DOM_ID_W = 8,
  parameter bit FLUSH_REQ = 1'b1,
  parameter bit DEV_SEL_OK = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [63:0] active_root,
  output logic wbf_req,
  input wire logic wbf_done,
  output logic ctx_inv_req,
  output rrc_ctx_inv_s ctx_inv,
  input wire logic ctx_inv_done,
  output logic tlb_inv_req,
  output logic [63:0] tlb_addr,
  input wire logic tlb_inv_done
);
  if (HOST_ADDR_W < 13 || HOST_ADDR_W > 64 || DOM_ID_W < 1 || DOM_ID_W > 16) begin : g_bad_cfg
    $error("rrc_remap_ctl: unsupported address or domain width");
  end

  localparam logic [63:0] ROOT_MASK = ((64'h1 << HOST_ADDR_W) - 64'h1) & ROOT_PAGE_MASK;
  localparam logic [15:0] DOM_ID_MASK = 16'((32'h1 << DOM_ID_W) - 32'h1);
  localparam logic [9:0] ADDR_OFS_VAL = 10'(IVA_LO >> 4);

  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] root_lo_r, root_hi_r;
  logic [63:0] active_root_r;
  logic set_root_pend_r, rps_r;
  logic ctx_busy_r;
  logic [1:0] req_gran_r, act_gran_r;
  logic [15:0] dom_id_r, src_id_r;
  logic [1:0] func_mask_r;
  rrc_ctx_e ctx_st_r;
  logic wbf_req_r, ctx_req_r;
  rrc_ctx_inv_s ctx_inv_r;
  logic [31:0] iva_lo_r, iva_hi_r, tlb_hi_r;
  logic tlb_req_r;

  logic access, wr, rd_phase, hit;
  logic [31:0] rd_val;
  logic ccmd_start, tlb_start;
  logic [1:0] gran_done;

  // The answer is registered, so every access takes one wait state.
  assign access = psel & penable & pready_r;
  assign wr = access & pwrite;
  assign rd_phase = psel & penable & ~pready_r;
  assign ccmd_start = wr && paddr == CCMD_HI && pstrb[3] && pwdata[31] && !ctx_busy_r;
  assign tlb_start = wr && paddr == TLB_HI && pstrb[3] && pwdata[31] && !tlb_hi_r[31];

  // Coarsening: device scope falls back to domain when unsupported, reserved to global.
  always_comb begin
    unique case (req_gran_r)
      GRAN_DEVICE: gran_done = DEV_SEL_OK ? GRAN_DEVICE : GRAN_DOMAIN;
      GRAN_DOMAIN: gran_done = GRAN_DOMAIN;
      GRAN_GLOBAL: gran_done = GRAN_GLOBAL;
      GRAN_RSVD: gran_done = GRAN_GLOBAL;
    endcase
  end

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0;
    unique case (paddr)
      CAP_LO: rd_val = 32'(FLUSH_REQ) << FLUSH_REQ_POS;
      CAP_HI: rd_val = 32'h0;
      ECAP_LO: rd_val = 32'(ADDR_OFS_VAL) << ADDR_OFS_POS;
      ECAP_HI: rd_val = 32'h0;
      CTRL: rd_val = 32'(rps_r) << RPS_POS;
      ROOT_LO: rd_val = root_lo_r;
      ROOT_HI: rd_val = root_hi_r;
      CCMD_LO: rd_val = {16'h0, dom_id_r};
      CCMD_HI: rd_val = {ctx_busy_r, req_gran_r, act_gran_r, 27'h0};
      IVA_LO: rd_val = 32'h0;
      IVA_HI: rd_val = 32'h0;
      TLB_LO: rd_val = 32'h0;
      TLB_HI: rd_val = tlb_hi_r;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= rd_phase;
      pslverr_r <= rd_phase & ~hit;
      prdata_r <= (rd_phase && !pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      root_lo_r <= ROOT_RESET[31:0];
      root_hi_r <= ROOT_RESET[63:32];
    end else if (wr && paddr == ROOT_LO) begin
      root_lo_r <= rrc_merge(root_lo_r, pwdata, pstrb) & ROOT_MASK[31:0];
    end else if (wr && paddr == ROOT_HI) begin
      root_hi_r <= rrc_merge(root_hi_r, pwdata, pstrb) & ROOT_MASK[63:32];
    end
  end

  // Adoption takes one cycle so status is seen low before the new pointer is live.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_root_pend_r <= 1'b0;
      rps_r <= 1'b0;
      active_root_r <= ROOT_RESET;
    end else if (wr && paddr == CTRL && pstrb[0] && pwdata[SET_ROOT_POS]) begin
      set_root_pend_r <= 1'b1;
      rps_r <= 1'b0;
    end else if (set_root_pend_r) begin
      set_root_pend_r <= 1'b0;
      active_root_r <= {root_hi_r, root_lo_r};
      rps_r <= 1'b1;
    end
  end

  // Writes while an invalidation runs are dropped, since software must not make them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_id_r <= 16'h0;
      src_id_r <= 16'h0;
      func_mask_r <= 2'h0;
      req_gran_r <= GRAN_RSVD;
    end else if (wr && !ctx_busy_r) begin
      if (paddr == CCMD_LO) begin
        {src_id_r, dom_id_r} <= rrc_merge({src_id_r, dom_id_r}, pwdata, pstrb)
          & {16'hffff, DOM_ID_MASK};
      end else if (paddr == CCMD_HI) begin
        if (pstrb[0]) begin
          func_mask_r <= pwdata[1:0];
        end
        if (pstrb[3]) begin
          req_gran_r <= pwdata[30:29];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_st_r <= CTX_IDLE;
      ctx_busy_r <= 1'b0;
      act_gran_r <= GRAN_RSVD;
      wbf_req_r <= 1'b0;
      ctx_req_r <= 1'b0;
      ctx_inv_r <= '0;
    end else begin
      wbf_req_r <= 1'b0;
      ctx_req_r <= 1'b0;
      unique case (ctx_st_r)
        CTX_IDLE: begin
          if (ccmd_start) begin
            // One cycle always passes first, so the command latched with the start is sent.
            ctx_busy_r <= 1'b1;
            wbf_req_r <= FLUSH_REQ;
            ctx_st_r <= CTX_FLUSH;
          end
        end
        CTX_FLUSH: begin
          if (wbf_done || !FLUSH_REQ) begin
            ctx_req_r <= 1'b1;
            ctx_st_r <= CTX_INV;
          end
        end
        CTX_INV: begin
          if (ctx_inv_done) begin
            ctx_busy_r <= 1'b0;
            act_gran_r <= gran_done;
            ctx_st_r <= CTX_IDLE;
          end
        end
      endcase
      if (ctx_st_r != CTX_INV) begin
        ctx_inv_r.gran <= gran_done;
        ctx_inv_r.dom_id <= dom_id_r;
        ctx_inv_r.src_id <= src_id_r;
        ctx_inv_r.func_care <= 3'h7 >> func_mask_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iva_lo_r <= 32'h0;
      iva_hi_r <= 32'h0;
      tlb_hi_r <= 32'h0;
      tlb_req_r <= 1'b0;
    end else begin
      tlb_req_r <= tlb_start;
      if (wr && paddr == IVA_LO && !tlb_hi_r[31]) begin
        iva_lo_r <= rrc_merge(iva_lo_r, pwdata, pstrb);
      end
      if (wr && paddr == IVA_HI && !tlb_hi_r[31]) begin
        iva_hi_r <= rrc_merge(iva_hi_r, pwdata, pstrb);
      end
      if (wr && paddr == TLB_HI && !tlb_hi_r[31]) begin
        tlb_hi_r <= rrc_merge(tlb_hi_r, pwdata, pstrb) & TLB_HI_MASK;
      end else if (tlb_hi_r[31] && tlb_inv_done) begin
        tlb_hi_r[31] <= 1'b0;
        tlb_hi_r[27:25] <= TLB_GRAN_GLOBAL;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign active_root = active_root_r;
  assign wbf_req = wbf_req_r;
  assign ctx_inv_req = ctx_req_r;
  assign ctx_inv = ctx_inv_r;
  assign tlb_inv_req = tlb_req_r;
  assign tlb_addr = {iva_hi_r, iva_lo_r};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  root_impl_bits_a: assert property ((({root_hi_r, root_lo_r} & ~ROOT_MASK) == 64'h0))
    else $error("root base holds unimplemented bits");
  root_readback_a: assert property (rd_phase && !pwrite && paddr == ROOT_LO |=>
    prdata_r == $past(root_lo_r) && pready_r)
    else $error("root base read does not return stored value");
  root_status_a: assert property (wr && paddr == CTRL && pstrb[0] && pwdata[SET_ROOT_POS] |=>
    !rps_r ##1 rps_r && active_root_r == {root_hi_r, root_lo_r})
    else $error("root pointer status sequence wrong");
  icc_start_a: assert property (ccmd_start |=> ctx_busy_r && ctx_st_r != CTX_IDLE)
    else $error("invalidation did not start");
  icc_finish_a: assert property (ctx_st_r == CTX_INV && ctx_inv_done |=>
    !ctx_busy_r && act_gran_r == $past(gran_done))
    else $error("completion not reported");
  flush_first_a: assert property (FLUSH_REQ && ccmd_start |=> wbf_req_r && !ctx_req_r)
    else $error("context invalidated before write buffer flush");
  device_gran_a: assert property ($fell(ctx_busy_r) && act_gran_r == GRAN_DEVICE |->
    req_gran_r == GRAN_DEVICE)
    else $error("device scope reported for coarser request");
  func_care_a: assert property (ctx_req_r |-> ctx_inv_r.func_care ==
    (func_mask_r == 2'h0 ? 3'h7 : (func_mask_r == 2'h1 ? 3'h3 : (func_mask_r == 2'h2 ? 3'h1 : 3'h0))))
    else $error("function mask applied wrongly");
  wo_fields_a: assert property (rd_phase && !pwrite && paddr == CCMD_LO |=>
    prdata_r[31:16] == 16'h0)
    else $error("write-only field leaked on read");
  did_width_a: assert property ((dom_id_r & ~DOM_ID_MASK) == 16'h0)
    else $error("domain bits beyond width stored");
endmodule : rrc_remap_ctl

// [test_remap_root_and_context_invalidate.sv]
`timescale 1ns/1ps
module test_remap_root_and_context_invalidate;
  import rrc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic wbf_req, wbf_done, ctx_inv_req, ctx_inv_done, tlb_inv_req, tlb_inv_done, seen;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [63:0] active_root, tlb_addr;
  logic [1:0] act;
  rrc_ctx_inv_s ctx_inv;
  int n_mismatch, n_checks, cyc;

  rrc_remap_ctl #(.HOST_ADDR_W(39), .DOM_ID_W(8), .FLUSH_REQ(1'b1), .DEV_SEL_OK(1'b1)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .active_root(active_root), .wbf_req(wbf_req), .wbf_done(wbf_done),
    .ctx_inv_req(ctx_inv_req), .ctx_inv(ctx_inv), .ctx_inv_done(ctx_inv_done),
    .tlb_inv_req(tlb_inv_req), .tlb_addr(tlb_addr), .tlb_inv_done(tlb_inv_done));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // The limit is far above the few hundred cycles the sequence needs.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdreg(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask : rdreg

  // Software waits on the busy or status bit by polling, never by counting cycles.
  task automatic poll(input logic [ADDR_W-1:0] a, input int b, input logic v);
    do rdreg(a); while (rd[b] !== v);
  endtask : poll

  // The pulse may rise at the very edge the caller returned on, so look before waiting.
  task automatic wait_pulse(input int w);
    #1;
    while ((w == 0 ? wbf_req : (w == 1 ? ctx_inv_req : tlb_inv_req)) !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
  endtask : wait_pulse

  task automatic pulse(input int w);
    @(posedge pclk);
    if (w == 0) wbf_done <= 1'b1;
    else if (w == 1) ctx_inv_done <= 1'b1;
    else tlb_inv_done <= 1'b1;
    @(posedge pclk);
    wbf_done <= 1'b0;
    ctx_inv_done <= 1'b0;
    tlb_inv_done <= 1'b0;
  endtask : pulse

  initial begin
    {psel, penable, pwrite, wbf_done, ctx_inv_done, tlb_inv_done, presetn} = 7'h0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdreg(ROOT_LO);
    chk("root_lo_reset", 64'h0, rd);
    rdreg(12'h200);
    chk("unmapped_err", 64'h1, last_err);
    chk("unmapped_data", 64'h0, rd);
    wr(ROOT_LO, 32'hdead_beef);
    wr(ROOT_HI, 32'hffff_ffff);
    rdreg(ROOT_LO);
    chk("root_lo", 64'hdead_b000, rd);
    rdreg(ROOT_HI);
    chk("root_hi", 64'h7f, rd);
    wr(CTRL, 32'h1);
    poll(CTRL, RPS_POS, 1'b1);
    chk("active_root", 64'h0000_007f_dead_b000, active_root);
    rdreg(CAP_LO);
    chk("flush_flag", 64'h1, rd[FLUSH_REQ_POS]);
    apb(1'b1, CCMD_HI, 32'hffff_ffff, 4'h7);
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      #1;
      seen = seen | wbf_req | ctx_inv_req;
    end
    chk("no_start", 64'h0, seen);
    for (int g = 0; g < 4; g++) begin
      act = (g == 3) ? GRAN_DEVICE : ((g == 2) ? GRAN_DOMAIN : GRAN_GLOBAL);
      wr(CCMD_LO, 32'h1234_5eab);
      wr(CCMD_HI, {1'b1, 2'(g), 27'h0, 2'h2});
      wait_pulse(0);
      chk("inv_before_flush", 64'h0, ctx_inv_req);
      rdreg(CCMD_HI);
      chk("busy_bit", 64'h1, rd[31]);
      pulse(0);
      wait_pulse(1);
      chk("gran", 64'(act), ctx_inv.gran);
      chk("dom_id", 64'h00ab, ctx_inv.dom_id);
      chk("src_id", 64'h1234, ctx_inv.src_id);
      chk("func_care", 64'h1, ctx_inv.func_care);
      pulse(1);
      poll(CCMD_HI, 31, 1'b0);
      chk("ccmd_hi", {32'h0, 1'b0, 2'(g), act, 27'h0}, rd);
      rdreg(CCMD_LO);
      chk("ccmd_did", 64'h00ab, rd[15:0]);
    end
    rdreg(ECAP_LO);
    chk("addr_offset", 64'h010, rd[17:8]);
    wr(IVA_LO, 32'h0000_5000);
    wr(TLB_HI, 32'h9000_0000);
    wait_pulse(2);
    chk("tlb_addr", 64'h5000, tlb_addr);
    pulse(2);
    poll(TLB_HI, 31, 1'b0);
    chk("tlb_done", 64'h0, rd[31]);
    stop_test();
  end
endmodule : test_remap_root_and_context_invalidate
